// [logic/opc_pkg.sv]
// shared constants and types for the operator panel controller
package opc_pkg;
  // mode indicators in mode-key order
  typedef enum logic [2:0] {
    OI_FREQ_REF, OI_OUT_FREQ, OI_OUT_CUR, OI_MONITOR,
    OI_DIR, OI_LOC_REM, OI_PROGRAM
  } opc_ind_type;
  // program-mode edit states
  typedef enum logic {PE_NUM, PE_VAL} opc_pedit_type;
  // register byte offsets
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_FREQ_REF = 8'h08;
  localparam logic [7:0] OFS_MONITOR = 8'h0C;
  localparam logic [7:0] OFS_PARAM = 8'h10;
  // config field positions
  localparam int CFG_STOP_DIS = 0;
  localparam int CFG_IMMED = 1;
  localparam int CFG_REF_SRC = 2;
  localparam int CFG_LOC_REF = 3;
  localparam int CFG_UNIT_LO = 4;
  localparam int CFG_W = 6;
  localparam logic [5:0] CFG_RESET = 6'h00; // unit 0 = hertz
  // item number ranges
  localparam logic [3:0] MON_FIRST = 4'h1;
  localparam logic [3:0] MON_LAST = 4'hA;
  localparam logic [7:0] FIRST_PARAMETER = 8'h01;
  localparam logic [7:0] LAST_PARAMETER = 8'hB3;
  localparam logic [15:0] FREQ_REF_RESET = 16'h0000;
  // pin inputs: six keys then the two run terminals
  localparam int K_MODE = 0;
  localparam int K_INC = 1;
  localparam int K_DEC = 2;
  localparam int K_ENTER = 3;
  localparam int K_RUN = 4;
  localparam int K_STOP = 5;
  localparam int T_FWD = 6;
  localparam int T_REV = 7;
  localparam int NPIN = 8;
endpackage : opc_pkg

// [logic/opc_panel.sv]
// operator panel controller: keypad, indicators, edits and run gating
//
// Contract
// - mode key advances one indicator per press, starting at frequency ref
// - power-up restores out freq or current indicator, else frequency ref
// - monitor indicator selects items one through ten
// - program indicator views or sets parameters first through last
// - while running, program mode only edits the allowed subset
// - run terminal input ignored while program indicator lit
// - run terminal input ignored while loc/rem indicator lit
// - loc/rem choice fixed while the drive runs
// - direction selectable under direction indicator when keypad-operated
// - mode key discards an uncommitted edit
// - increment raises, decrement lowers the edited number or value
// - enter commits the edited number or value
// - keypad run key starts only in local keypad operation
// - stop key stops unless disabled; resets fault when faulted
// - keypad fault reset ignored while a run command is active
// - pending frequency edit flashes; enter returns steady display
// - immediate-entry setting applies inc and dec at once, steady
// - frequency editing gated by source, local setting or multi-step
// - frequency edits accepted while running
// - display unit follows display-unit setting, hertz by default
`timescale 1ns/1ns
module opc_panel import opc_pkg::*; #(
  parameter int VAL_W = 16,
  parameter logic [15:0] FREQ_REF_MAX = 16'hFFFF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NPIN-1:0] pin_in,
  input wire logic drive_running,
  input wire logic drive_fault,
  input wire logic [2:0] step_sel,
  input wire logic [2:0] saved_ind,
  input wire logic param_live_ok,
  input wire logic [VAL_W-1:0] param_rdata,
  input wire logic [VAL_W-1:0] out_freq,
  input wire logic [VAL_W-1:0] out_current,
  input wire logic [VAL_W-1:0] mon_data,
  output logic [6:0] ind_leds,
  output logic [2:0] ind_code,
  output logic [VAL_W-1:0] display,
  output logic display_flash,
  output logic [1:0] display_unit,
  output logic [VAL_W-1:0] freq_ref,
  output logic [3:0] mon_sel,
  output logic param_wr,
  output logic [7:0] param_num,
  output logic [VAL_W-1:0] param_wdata,
  output logic run_fwd,
  output logic run_rev,
  output logic stop_cmd,
  output logic fault_reset,
  output logic local_mode,
  output logic dir_rev
);
  ////////////////////////////////////////////////////////////////////
  // pin synchronisers and key press detection
  logic [NPIN-1:0] s1_reg, s2_reg, s3_reg, lvl_reg, lvl_d_reg;
  logic [NPIN-1:0] press;
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_pin
      // level only moves when stages two and three agree
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_reg[gi] <= 1'b0;
          s2_reg[gi] <= 1'b0;
          s3_reg[gi] <= 1'b0;
          lvl_reg[gi] <= 1'b0;
          lvl_d_reg[gi] <= 1'b0;
        end else if (ce) begin
          s1_reg[gi] <= pin_in[gi];
          s2_reg[gi] <= s1_reg[gi];
          s3_reg[gi] <= s2_reg[gi];
          if (s2_reg[gi] == s3_reg[gi]) lvl_reg[gi] <= s3_reg[gi];
          lvl_d_reg[gi] <= lvl_reg[gi];
        end
      end
      assign press[gi] = lvl_reg[gi] & ~lvl_d_reg[gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // configuration and common terms
  logic [CFG_W-1:0] cfg_reg;
  opc_ind_type ind_reg;
  opc_pedit_type pstate_reg;
  logic boot_reg, local_reg, dir_reg, key_run_reg;
  logic [VAL_W-1:0] freq_ref_indicator_reg, fedit_reg, pval_reg;
  logic fpend_reg, mon_show_reg, ppend_reg;
  logic [3:0] mon_num_reg, mon_sel_reg;
  logic [7:0] pnum_reg;
  logic apb_wr, freq_ref_indicator_ok, run_active, term_gate;
  logic [VAL_W-1:0] freq_ref_indicator_step;
  assign apb_wr = psel & penable & pready & pwrite;
  // keypad may edit frequency only from these sources
  assign freq_ref_indicator_ok = (!local_reg && cfg_reg[CFG_REF_SRC]) ||
                   (local_reg && cfg_reg[CFG_LOC_REF]) ||
                   (step_sel != 3'h0);
  assign run_active = lvl_reg[T_FWD] | lvl_reg[T_REV] | key_run_reg;
  // terminals count only outside program and loc/rem
  assign term_gate = (ind_reg != OI_PROGRAM) && (ind_reg != OI_LOC_REM);
  // saturating next value, ends of range hold
  assign freq_ref_indicator_step = (press[K_INC] && fedit_reg != FREQ_REF_MAX) ?
                     fedit_reg + 1'b1 :
                     (press[K_DEC] && fedit_reg != '0) ?
                     fedit_reg - 1'b1 : fedit_reg;

  ////////////////////////////////////////////////////////////////////
  // indicator selection and power-up restore
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ind_reg <= OI_FREQ_REF;
      boot_reg <= 1'b1;
    end else if (ce) begin
      boot_reg <= 1'b0;
      if (boot_reg) begin
        // only the two output monitors survive power-down
        if (saved_ind == 3'(OI_OUT_FREQ) || saved_ind == 3'(OI_OUT_CUR))
          ind_reg <= opc_ind_type'(saved_ind);
      end else if (press[K_MODE]) begin
        // one step per press, wrap after program
        if (ind_reg == OI_PROGRAM) ind_reg <= OI_FREQ_REF;
        else ind_reg <= opc_ind_type'(ind_reg + 3'h1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // frequency reference edit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freq_ref_indicator_reg <= FREQ_REF_RESET;
      fedit_reg <= FREQ_REF_RESET;
      fpend_reg <= 1'b0;
    end else if (ce) begin
      if (apb_wr && paddr == OFS_FREQ_REF) begin
        freq_ref_indicator_reg <= pwdata[VAL_W-1:0];
        fedit_reg <= pwdata[VAL_W-1:0];
        fpend_reg <= 1'b0;
      end else if (ind_reg != OI_FREQ_REF || press[K_MODE]) begin
        fedit_reg <= freq_ref_indicator_reg;
        fpend_reg <= 1'b0;
      end else if (freq_ref_indicator_ok && (press[K_INC] ^ press[K_DEC])) begin
        // saturating edit, allowed while running too
        fedit_reg <= freq_ref_indicator_step;
        // immediate entry skips the pending stage
        if (cfg_reg[CFG_IMMED]) freq_ref_indicator_reg <= freq_ref_indicator_step;
        fpend_reg <= ~cfg_reg[CFG_IMMED];
      end else if (press[K_ENTER] && fpend_reg) begin
        freq_ref_indicator_reg <= fedit_reg;
        fpend_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // monitor item selection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mon_num_reg <= MON_FIRST;
      mon_sel_reg <= MON_FIRST;
      mon_show_reg <= 1'b0;
    end else if (ce) begin
      if (ind_reg != OI_MONITOR || press[K_MODE]) begin
        mon_num_reg <= mon_sel_reg;
        mon_show_reg <= 1'b0;
      end else if (press[K_ENTER]) begin
        // commit item and show its data
        mon_sel_reg <= mon_num_reg;
        mon_show_reg <= 1'b1;
      end else if (!mon_show_reg) begin
        if (press[K_INC] && mon_num_reg != MON_LAST)
          mon_num_reg <= mon_num_reg + 4'h1;
        else if (press[K_DEC] && mon_num_reg != MON_FIRST)
          mon_num_reg <= mon_num_reg - 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // parameter number and value edit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pstate_reg <= PE_NUM;
      pnum_reg <= FIRST_PARAMETER;
      pval_reg <= '0;
      ppend_reg <= 1'b0;
      param_wr <= 1'b0;
    end else if (ce) begin
      param_wr <= 1'b0;
      if (ind_reg != OI_PROGRAM || press[K_MODE]) begin
        pstate_reg <= PE_NUM;
        ppend_reg <= 1'b0;
      end else unique case (pstate_reg)
        PE_NUM: begin
          // number range first to last parameter
          if (press[K_INC] && pnum_reg != LAST_PARAMETER)
            pnum_reg <= pnum_reg + 8'h01;
          else if (press[K_DEC] && pnum_reg != FIRST_PARAMETER)
            pnum_reg <= pnum_reg - 8'h01;
          else if (press[K_ENTER]) begin
            pval_reg <= param_rdata;
            pstate_reg <= PE_VAL;
          end
        end
        PE_VAL: begin
          if (press[K_ENTER]) begin
            // write only when stopped or in the live subset
            param_wr <= ppend_reg && (!drive_running || param_live_ok);
            ppend_reg <= 1'b0;
            pstate_reg <= PE_NUM;
          end else if (!drive_running || param_live_ok) begin
            if (press[K_INC] && !press[K_DEC]) begin
              pval_reg <= pval_reg + 1'b1;
              ppend_reg <= 1'b1;
            end else if (press[K_DEC] && !press[K_INC]) begin
              pval_reg <= pval_reg - 1'b1;
              ppend_reg <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // local/remote, direction and run/stop commands
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      local_reg <= 1'b0;
      dir_reg <= 1'b0;
      key_run_reg <= 1'b0;
      run_fwd <= 1'b0;
      run_rev <= 1'b0;
      stop_cmd <= 1'b0;
      fault_reset <= 1'b0;
    end else if (ce) begin
      stop_cmd <= 1'b0;
      fault_reset <= 1'b0;
      if (ind_reg == OI_LOC_REM && !drive_running &&
          (press[K_INC] ^ press[K_DEC]))
        local_reg <= ~local_reg;
      if (ind_reg == OI_DIR && local_reg) begin
        if (press[K_INC]) dir_reg <= 1'b0;
        else if (press[K_DEC]) dir_reg <= 1'b1;
      end
      if (press[K_STOP]) begin
        if (drive_fault) begin
          // fault reset refused under an active run command
          fault_reset <= ~run_active;
        end else if (!cfg_reg[CFG_STOP_DIS]) begin
          stop_cmd <= 1'b1;
          key_run_reg <= 1'b0;
        end
      end else if (press[K_RUN] && local_reg && term_gate) begin
        // keypad run only in local operation
        key_run_reg <= 1'b1;
      end
      if (!local_reg) key_run_reg <= 1'b0;
      run_fwd <= local_reg ? key_run_reg & ~dir_reg
                           : term_gate & lvl_reg[T_FWD];
      run_rev <= local_reg ? key_run_reg & dir_reg
                           : term_gate & lvl_reg[T_REV];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // panel outputs, all registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ind_leds <= 7'h01;
      ind_code <= 3'h0;
      display <= '0;
      display_flash <= 1'b0;
      display_unit <= 2'h0;
      freq_ref <= FREQ_REF_RESET;
      mon_sel <= MON_FIRST;
      param_num <= FIRST_PARAMETER;
      param_wdata <= '0;
      local_mode <= 1'b0;
      dir_rev <= 1'b0;
    end else if (ce) begin
      ind_leds <= 7'h01 << ind_reg;
      ind_code <= ind_reg;
      // flash only while a frequency edit waits for enter
      display_flash <= fpend_reg && ind_reg == OI_FREQ_REF;
      display_unit <= cfg_reg[CFG_UNIT_LO +: 2];
      freq_ref <= freq_ref_indicator_reg;
      mon_sel <= mon_sel_reg;
      param_num <= pnum_reg;
      param_wdata <= pval_reg;
      local_mode <= local_reg;
      dir_rev <= dir_reg;
      unique case (ind_reg)
        OI_FREQ_REF: display <= fedit_reg;
        OI_OUT_FREQ: display <= out_freq;
        OI_OUT_CUR: display <= out_current;
        OI_MONITOR: display <= mon_show_reg ? mon_data
                                           : VAL_W'(mon_num_reg);
        OI_DIR: display <= VAL_W'(dir_reg);
        OI_LOC_REM: display <= VAL_W'(local_reg);
        OI_PROGRAM: display <= (pstate_reg == PE_VAL) ? pval_reg
                                                     : VAL_W'(pnum_reg);
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // apb slave: zero-wait, registered answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg <= CFG_RESET;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (ce) begin
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      if (apb_wr && paddr == OFS_CONFIG) cfg_reg <= pwdata[CFG_W-1:0];
      if (psel && !penable) begin
        prdata <= 32'h00000000;
        unique case (paddr)
          OFS_CONFIG: prdata <= 32'(cfg_reg);
          OFS_STATUS: prdata <= 32'({key_run_reg, drive_fault,
                           drive_running, dir_reg, local_reg,
                           ppend_reg, fpend_reg, 1'b0, ind_reg});
          OFS_FREQ_REF: prdata <= 32'(freq_ref_indicator_reg);
          OFS_MONITOR: prdata <= 32'({mon_num_reg, mon_sel_reg});
          OFS_PARAM: prdata <= 32'({pval_reg, pnum_reg});
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  sequence s_mode_press;
    press[K_MODE] && !boot_reg && ce;
  endsequence
  sequence s_freq_ref_indicator_edit;
    ind_reg == OI_FREQ_REF && freq_ref_indicator_ok && press[K_INC] && !press[K_DEC]
      && !press[K_MODE] && !apb_wr && !cfg_reg[CFG_IMMED] && ce;
  endsequence
  chk_mode_wraps: assert property (@(posedge pclk) disable iff (!presetn)
    s_mode_press and ind_reg == OI_PROGRAM |=> ind_reg == OI_FREQ_REF)
    else $error("mode key did not wrap");
  chk_mode_steps: assert property (@(posedge pclk) disable iff (!presetn)
    s_mode_press and ind_reg != OI_PROGRAM |=>
      ind_reg == $past(ind_reg) + 3'h1)
    else $error("mode key did not step once");
  chk_boot_restore: assert property (@(posedge pclk) disable iff (!presetn)
    boot_reg && ce && saved_ind == 3'(OI_OUT_CUR) |=> ind_reg == OI_OUT_CUR)
    else $error("indicator not restored");
  chk_mon_range: assert property (@(posedge pclk) disable iff (!presetn)
    mon_num_reg >= MON_FIRST && mon_num_reg <= MON_LAST)
    else $error("monitor item out of range");
  chk_param_range: assert property (@(posedge pclk) disable iff (!presetn)
    pnum_reg >= FIRST_PARAMETER && pnum_reg <= LAST_PARAMETER)
    else $error("parameter number out of range");
  chk_param_live: assert property (@(posedge pclk) disable iff (!presetn)
    param_wr |-> $past(!drive_running || param_live_ok))
    else $error("parameter written while locked");
  chk_term_gate: assert property (@(posedge pclk) disable iff (!presetn)
    ce && (ind_reg == OI_PROGRAM || ind_reg == OI_LOC_REM) && !local_reg
      |=> !run_fwd && !run_rev)
    else $error("run terminal passed in gated mode");
  chk_fault_hold: assert property (@(posedge pclk) disable iff (!presetn)
    ce && press[K_STOP] && drive_fault && run_active |=> !fault_reset)
    else $error("fault reset under run command");
  chk_stop_dis: assert property (@(posedge pclk) disable iff (!presetn)
    stop_cmd |-> $past(!cfg_reg[CFG_STOP_DIS] && !drive_fault))
    else $error("stop issued while disabled");
  chk_edit_flash: assert property (@(posedge pclk) disable iff (!presetn)
    s_freq_ref_indicator_edit ##1 (ce && ind_reg == OI_FREQ_REF && !press[K_MODE]
      && !apb_wr && !press[K_ENTER])[*1] ##1 1'b1 |-> display_flash)
    else $error("pending edit does not flash");
  chk_loc_fixed: assert property (@(posedge pclk) disable iff (!presetn)
    drive_running && ce |=> local_reg == $past(local_reg))
    else $error("source changed while running");
endmodule : opc_panel

// [sim/opc_operator.sv]
// keypad operator model: presses keys and holds run terminals
`timescale 1ns/1ns
module opc_operator import opc_pkg::*; (
  input wire logic pclk,
  output logic [NPIN-1:0] pin_in
);
  // released keys read low, as the pins are pulled down
  initial pin_in = '0;
  ////////////////////////////////////////////////////////////////////////
  // one press: held past the sync stages, then released long enough
  // that the next press is seen as a fresh edge
  task automatic press(input int k);
    @(posedge pclk);
    pin_in[k] <= 1'b1;
    repeat (8) @(posedge pclk);
    pin_in[k] <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask : press
  // run terminals are levels held until changed
  task automatic hold(input int k, input logic v);
    @(posedge pclk);
    pin_in[k] <= v;
    repeat (8) @(posedge pclk);
  endtask : hold
endmodule : opc_operator

// [sim/tb_operator_panel_controller.sv]
// self-checking bench for the operator panel controller
`timescale 1ns/1ns
`define CHK(g, x) begin checks_done++; if ((g) !== (x)) begin n_errors++; \
  $display("MISMATCH %0t got %0h exp %0h", $time, g, x); end end
module tb_operator_panel_controller import opc_pkg::*; ;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q, r, cfg;
  logic e, display_flash, param_wr, run_fwd, run_rev, stop_cmd;
  logic fault_reset, local_mode, dir_rev;
  logic drive_running = 1'b0, drive_fault = 1'b0, param_live_ok = 1'b0;
  logic [2:0] step_sel = '0, saved_ind = '0, ind_code;
  logic [15:0] param_rdata, out_freq, out_current, mon_data, v;
  logic [15:0] display, freq_ref, param_wdata;
  logic [NPIN-1:0] pin_in;
  logic [6:0] ind_leds;
  logic [1:0] display_unit;
  logic [3:0] mon_sel;
  logic [7:0] param_num;
  logic [31:0] seed = 32'h9570;
  int n_errors = 0, checks_done = 0, n_stop = 0, n_frst = 0, cur = 0, n;
  int n_pwr = 0;

  always #10 pclk = ~pclk;
  opc_operator op_u (.pclk(pclk), .pin_in(pin_in));
  opc_panel dut_u (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
    .drive_running(drive_running), .drive_fault(drive_fault),
    .step_sel(step_sel), .saved_ind(saved_ind),
    .param_live_ok(param_live_ok), .param_rdata(param_rdata),
    .out_freq(out_freq), .out_current(out_current), .mon_data(mon_data),
    .ind_leds(ind_leds), .ind_code(ind_code), .display(display),
    .display_flash(display_flash), .display_unit(display_unit),
    .freq_ref(freq_ref), .mon_sel(mon_sel), .param_wr(param_wr),
    .param_num(param_num), .param_wdata(param_wdata), .run_fwd(run_fwd),
    .run_rev(run_rev), .stop_cmd(stop_cmd), .fault_reset(fault_reset),
    .local_mode(local_mode), .dir_rev(dir_rev));
  // one-cycle pulses are counted, so a scenario compares counts
  always @(posedge pclk) begin
    if (stop_cmd === 1'b1) n_stop++;
    if (fault_reset === 1'b1) n_frst++;
    if (param_wr === 1'b1) n_pwr++;
  end
  ////////////////////////////////////////////////////////////////////////
  // xorshift source, fixed start so runs repeat
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic complete_run();
    if (n_errors == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run
  // apb transfer; result left in q and e, wait bounded
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) begin
      n_errors++;
      complete_run();
    end
  endtask : apb
  task automatic do_reset(input logic [2:0] s);
    saved_ind <= s;
    presetn <= 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    cur = 0;
  endtask : do_reset
  // mode presses until target, each step checked
  task automatic mode_to(input int t);
    int k;
    for (k = 0; k < 8 && cur != t; k++) begin
      op_u.press(K_MODE);
      cur = (cur + 1) % 7;
      `CHK(ind_leds, 7'h01 << cur)
      `CHK(ind_code, 3'(cur))
    end
  endtask : mode_to
  initial begin
    repeat (100000) @(posedge pclk);
    n_errors++;
    complete_run();
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    r = rnd();
    out_freq = r[15:0];
    out_current = r[31:16];
    r = rnd();
    mon_data = r[15:0];
    param_rdata = r[31:16];
    do_reset(3'd0);
    `CHK(ind_leds, 7'h01)
    `CHK(mon_sel, 4'h1)
    // no source gate: edit refused; multi-step opens it
    op_u.press(K_INC);
    `CHK(display_flash, 1'b0)
    step_sel <= 3'd3;
    op_u.press(K_INC);
    `CHK(display_flash, 1'b1)
    // mode leaves the pending edit, a full lap returns
    op_u.press(K_MODE);
    cur = 1;
    mode_to(0);
    `CHK(freq_ref, 16'h0000)
    `CHK(display_flash, 1'b0)
    step_sel <= 3'd0;
    r = rnd();
    cfg = {26'h0, r[1:0], 4'h4};
    apb(1'b1, OFS_CONFIG, cfg);
    apb(1'b0, OFS_CONFIG, 32'h0);
    `CHK(q, cfg)
    `CHK(display_unit, cfg[5:4])
    apb(1'b0, 8'h20, 32'h0);
    `CHK(e, 1'b1)
    // random base, incs then one dec, committed by enter
    repeat (3) begin
      r = rnd();
      v = r[15:0] & 16'h7FFF;
      n = 1 + int'(r[17:16]);
      apb(1'b1, OFS_FREQ_REF, {16'h0, v});
      // write lands at the ready edge, output one edge later
      repeat (2) @(posedge pclk);
      `CHK(freq_ref, v)
      repeat (n) op_u.press(K_INC);
      op_u.press(K_DEC);
      `CHK(display_flash, 1'b1)
      `CHK(freq_ref, v)
      op_u.press(K_ENTER);
      v = v + 16'(n - 1);
      `CHK(freq_ref, v)
      `CHK(display_flash, 1'b0)
    end
    apb(1'b1, OFS_CONFIG, cfg | 32'h2);
    op_u.press(K_INC);
    `CHK(freq_ref, v + 16'h1)
    `CHK(display_flash, 1'b0)
    drive_running <= 1'b1;
    op_u.press(K_INC);
    `CHK(freq_ref, v + 16'h2)
    drive_running <= 1'b0;
    // clock enable low freezes the key path, so no step
    ce <= 1'b0;
    op_u.press(K_INC);
    ce <= 1'b1;
    op_u.press(K_MODE);
    cur = 1;
    mode_to(0);
    `CHK(freq_ref, v + 16'h2)
    apb(1'b1, OFS_CONFIG, cfg);
    // terminal run ignored under loc/rem and program
    op_u.hold(T_FWD, 1'b1);
    `CHK(run_fwd, 1'b1)
    op_u.hold(T_FWD, 1'b0);
    mode_to(5);
    op_u.hold(T_FWD, 1'b1);
    `CHK(run_fwd, 1'b0)
    op_u.hold(T_FWD, 1'b0);
    mode_to(6);
    op_u.hold(T_FWD, 1'b1);
    `CHK(run_fwd, 1'b0)
    op_u.hold(T_FWD, 1'b0);
    mode_to(0);
    // stop pulse, suppressed by the disable bit
    n = n_stop;
    op_u.press(K_STOP);
    `CHK(n_stop, n + 1)
    apb(1'b1, OFS_CONFIG, cfg | 32'h1);
    op_u.press(K_STOP);
    `CHK(n_stop, n + 1)
    apb(1'b1, OFS_CONFIG, cfg);
    // fault reset refused under an active run command
    drive_fault <= 1'b1;
    op_u.hold(T_FWD, 1'b1);
    n = n_frst;
    op_u.press(K_STOP);
    `CHK(n_frst, n)
    op_u.hold(T_FWD, 1'b0);
    op_u.press(K_STOP);
    `CHK(n_frst, n + 1)
    drive_fault <= 1'b0;
    // run key refused in remote, accepted in local
    op_u.press(K_RUN);
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK(q[10], 1'b0)
    mode_to(5);
    drive_running <= 1'b1;
    op_u.press(K_INC);
    `CHK(local_mode, 1'b0)
    drive_running <= 1'b0;
    op_u.press(K_INC);
    `CHK(local_mode, 1'b1)
    mode_to(4);
    op_u.press(K_DEC);
    `CHK(dir_rev, 1'b1)
    mode_to(0);
    op_u.press(K_RUN);
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK(q[10], 1'b1)
    `CHK(run_rev, 1'b1)
    // monitor item up to the tenth
    mode_to(3);
    repeat (9) op_u.press(K_INC);
    op_u.press(K_ENTER);
    `CHK(mon_sel, MON_LAST)
    `CHK(display, mon_data)
    mode_to(6);
    op_u.press(K_INC);
    op_u.press(K_ENTER);
    `CHK(param_num, 8'h02)
    op_u.press(K_INC);
    op_u.press(K_ENTER);
    `CHK(n_pwr, 1)
    `CHK(param_wdata, param_rdata + 16'h1)
    // power-up restores out current, not direction
    do_reset(3'd2);
    `CHK(ind_leds, 7'h04)
    `CHK(display, out_current)
    do_reset(3'd1);
    `CHK(ind_leds, 7'h02)
    `CHK(display, out_freq)
    do_reset(3'd4);
    `CHK(ind_leds, 7'h01)
    complete_run();
  end
endmodule : tb_operator_panel_controller
